/* File: common/tsw_pkg.sv */
package tsw_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFF_STATUS      = 4'h0;
  localparam logic [3:0]  OFF_IRQ_MASK    = 4'h4;
  localparam logic [3:0]  OFF_LAST_CMD    = 4'h8;
  localparam logic [15:0] STATUS_RST      = 16'h0000;
  localparam logic [15:0] MASK_RST        = 16'h0000;
  // ****************************************
  // status word fields
  // ****************************************
  localparam int          BIT_TX_RDY_RX_FILL = 15;
  localparam int          BIT_POWER_ON       = 14;
  localparam int          BIT_UNDERRUN_OVF   = 13;
  localparam int          BIT_WAKEUP_OVF     = 12;
  localparam int          BIT_EXT_INT_FALL   = 11;
  localparam int          BIT_LOW_SUPPLY     = 10;
  localparam int          BIT_RX_EMPTY       = 9;
  localparam int          BIT_SIG_STRENGTH   = 8;
  localparam int          BIT_DATA_QUALITY   = 7;
  localparam int          BIT_CLK_LOCK       = 6;
  localparam int          BIT_AFC_TOGGLE     = 5;
  localparam int          BIT_AFC_SIGN       = 4;
  localparam int          STICKY_W           = 5;
  // ****************************************
  // serial command port
  // ****************************************
  localparam int          CMD_BITS        = 16;
  localparam logic [4:0]  CNT_LAST        = 5'h0f;
  localparam logic        CMD_STATUS_LEAD = 1'b0;
  typedef enum logic [2:0] {
    TSW_IDLE  = 3'b000,
    TSW_FIRST = 3'b001,
    TSW_READ  = 3'b010,
    TSW_WRITE = 3'b011,
    TSW_DONE  = 3'b100
  } tsw_ser_state_t;
endpackage : tsw_pkg

/* File: src/tsw_sticky_flags.sv */
`timescale 1ns/1ps
module tsw_sticky_flags #(
  parameter int W = 5
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  output logic      [W-1:0] flags
);
  // ****************************************
  // clear-on-read flags
  // ****************************************
  // a set in the clearing cycle survives: no event is lost
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~{W{clr}}) | set;
    end
  end
endmodule : tsw_sticky_flags

/* File: src/tsw_afc_tracker.sv */
`timescale 1ns/1ps
module tsw_afc_tracker #(
  parameter int VAL_W = 4
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             cycle_done,
  input  wire logic             sign_in,
  input  wire logic [VAL_W-1:0] value_in,
  output logic                  afc_cycle_toggle,
  output logic                  afc_offset_sign,
  output logic      [VAL_W-1:0] afc_offset_value
);
  // ****************************************
  // afc cycle result
  // ****************************************
  // holding the result keeps it steady between cycles for the reader
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      afc_cycle_toggle <= 1'b0;
      afc_offset_sign  <= 1'b0;
      afc_offset_value <= '0;
    end else if (cycle_done) begin
      afc_cycle_toggle <= ~afc_cycle_toggle;
      afc_offset_sign  <= sign_in;
      afc_offset_value <= value_in;
    end
  end
endmodule : tsw_afc_tracker

/* File: src/tsw_status_word.sv */
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - low supply flag follows supply comparator
// - rx fifo empty flag reports fifo state
// - transmit mode: bit 8 shows antenna strength
// - receive mode: bit 8 shows rssi above limit
// - data quality indicator reported
// - clock recovery lock reported
// - toggle bit inverts per afc cycle
// - afc offset sign reported
// - four-bit signed offset in low bits
// - leading 0 reads status, 1 other commands
// - clear-on-read flags cleared after read
// - status word zero after reset
// - bit 15: tx ready or rx fill
// - power-on flag set after reset
// - bit 13: tx underrun or rx overflow
// - wake-up timer overflow sets flag
module tsw_status_word (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [15:0] bus_rdata,
  output logic             irq,
  input  wire logic        serial_sel_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_din,
  output logic             serial_dout,
  output logic             cmd_valid,
  output logic      [15:0] cmd_data,
  input  wire logic        tx_mode,
  input  wire logic        tx_reg_ready,
  input  wire logic        rx_fill_reached,
  input  wire logic        tx_underrun,
  input  wire logic        rx_overflow,
  input  wire logic        wakeup_overflow,
  input  wire logic        ext_int_fall,
  input  wire logic        low_supply_in,
  input  wire logic        rx_fifo_empty_in,
  input  wire logic        ant_strong,
  input  wire logic        rssi_above,
  input  wire logic        data_quality_in,
  input  wire logic        clock_lock_in,
  input  wire logic        afc_cycle_done,
  input  wire logic        afc_offset_sign_in,
  input  wire logic [3:0]  afc_offset_value_in
);
  // ****************************************
  // declarations
  // ****************************************
  logic [15:0]                  status_word_reg;
  logic [15:0]                  status_word_next;
  logic [15:0]                  irq_mask_reg;
  logic [15:0]                  last_cmd_reg;
  logic                         por_seen_reg;
  logic [tsw_pkg::STICKY_W-1:0] sticky_set;
  logic [tsw_pkg::STICKY_W-1:0] sticky_flags;
  logic                         read_clear;
  logic                         bus_status_rd;
  logic                         afc_cycle_toggle;
  logic                         afc_offset_sign;
  logic [3:0]                   afc_offset_value;
  logic                         sck_prev_reg;
  logic                         sck_rise;
  tsw_pkg::tsw_ser_state_t      ser_state_reg;
  tsw_pkg::tsw_ser_state_t      ser_state_next;
  logic [4:0]                   bit_cnt_reg;
  logic [15:0]                  shift_reg;
  logic                         ser_status_rd;

  // ****************************************
  // event flags
  // ****************************************
  // order of the vector: 4=bit15, 3=bit14, 2=bit13, 1=bit12, 0=bit11
  always_comb begin
    sticky_set[4] = tx_mode ? tx_reg_ready : rx_fill_reached;
    sticky_set[3] = ~por_seen_reg;
    sticky_set[2] = tx_mode ? tx_underrun : rx_overflow;
    sticky_set[1] = wakeup_overflow;
    sticky_set[0] = ext_int_fall;
  end

  // power-on flag raised once, in the first cycle after reset release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      por_seen_reg <= 1'b0;
    end else begin
      por_seen_reg <= 1'b1;
    end
  end

  assign bus_status_rd = bus_rd && (bus_addr == tsw_pkg::OFF_STATUS);
  assign read_clear    = bus_status_rd | ser_status_rd;

  tsw_sticky_flags #(
    .W (tsw_pkg::STICKY_W)
  ) u_sticky (
    .clock  (clock),
    .resetn (resetn),
    .set    (sticky_set),
    .clr    (read_clear),
    .flags  (sticky_flags)
  );

  tsw_afc_tracker #(
    .VAL_W (4)
  ) u_afc (
    .clock            (clock),
    .resetn           (resetn),
    .cycle_done       (afc_cycle_done),
    .sign_in          (afc_offset_sign_in),
    .value_in         (afc_offset_value_in),
    .afc_cycle_toggle (afc_cycle_toggle),
    .afc_offset_sign  (afc_offset_sign),
    .afc_offset_value (afc_offset_value)
  );

  // ****************************************
  // status word
  // ****************************************
  always_comb begin
    status_word_next = {sticky_flags,
                        low_supply_in,
                        rx_fifo_empty_in,
                        tx_mode ? ant_strong : rssi_above,
                        data_quality_in,
                        clock_lock_in,
                        afc_cycle_toggle,
                        afc_offset_sign,
                        afc_offset_value};
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_word_reg <= tsw_pkg::STATUS_RST;
    end else begin
      status_word_reg <= status_word_next;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_mask_reg <= tsw_pkg::MASK_RST;
    end else if (bus_wr && bus_addr == tsw_pkg::OFF_IRQ_MASK) begin
      irq_mask_reg <= bus_wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= 16'h0000;
    end else if (!bus_rd) begin
      bus_rdata <= 16'h0000;
    end else if (bus_addr == tsw_pkg::OFF_STATUS) begin
      // live word: a flag set one edge before the read is shown before it is cleared
      bus_rdata <= status_word_next;
    end else if (bus_addr == tsw_pkg::OFF_IRQ_MASK) begin
      bus_rdata <= irq_mask_reg;
    end else if (bus_addr == tsw_pkg::OFF_LAST_CMD) begin
      bus_rdata <= last_cmd_reg;
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // level output: stays high while any unmasked status bit is set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_word_next & irq_mask_reg);
    end
  end

  // ****************************************
  // serial command port
  // ****************************************
  // clock pin is sampled, so it must run well below half the core rate
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= serial_clk;
    end
  end

  assign sck_rise      = serial_clk & ~sck_prev_reg;
  assign ser_status_rd = (ser_state_reg == tsw_pkg::TSW_FIRST) && sck_rise
                         && (serial_din == tsw_pkg::CMD_STATUS_LEAD);

  always_comb begin
    ser_state_next = ser_state_reg;
    if (serial_sel_n) begin
      ser_state_next = tsw_pkg::TSW_IDLE;
    end else begin
      case (ser_state_reg)
        tsw_pkg::TSW_IDLE: begin
          ser_state_next = tsw_pkg::TSW_FIRST;
        end
        tsw_pkg::TSW_FIRST: begin
          if (sck_rise) begin
            ser_state_next = (serial_din == tsw_pkg::CMD_STATUS_LEAD) ?
                             tsw_pkg::TSW_READ : tsw_pkg::TSW_WRITE;
          end
        end
        tsw_pkg::TSW_READ, tsw_pkg::TSW_WRITE: begin
          if (sck_rise && bit_cnt_reg == tsw_pkg::CNT_LAST) begin
            ser_state_next = tsw_pkg::TSW_DONE;
          end
        end
        default: begin
          ser_state_next = ser_state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ser_state_reg <= tsw_pkg::TSW_IDLE;
    end else begin
      ser_state_reg <= ser_state_next;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_reg <= 5'h00;
    end else if (ser_state_reg == tsw_pkg::TSW_IDLE) begin
      bit_cnt_reg <= 5'h00;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // status snapshot taken at the leading bit so the word cannot tear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_reg   <= 16'h0000;
      serial_dout <= 1'b0;
    end else if (ser_status_rd) begin
      shift_reg   <= status_word_next;
      serial_dout <= status_word_next[15];
    end else if (ser_state_reg == tsw_pkg::TSW_READ && sck_rise) begin
      shift_reg   <= {shift_reg[14:0], 1'b0};
      serial_dout <= shift_reg[14];
    end else if (ser_state_reg == tsw_pkg::TSW_FIRST && sck_rise) begin
      shift_reg   <= {15'h0000, serial_din};
      serial_dout <= 1'b0;
    end else if (ser_state_reg == tsw_pkg::TSW_WRITE && sck_rise) begin
      shift_reg   <= {shift_reg[14:0], serial_din};
    end else if (ser_state_reg == tsw_pkg::TSW_IDLE) begin
      serial_dout <= 1'b0;
    end
  end

  // other commands are handed on whole; a copy is also kept in last_cmd_reg for bus reads
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_valid    <= 1'b0;
      cmd_data     <= 16'h0000;
      last_cmd_reg <= 16'h0000;
    end else if (ser_state_reg == tsw_pkg::TSW_WRITE && sck_rise
                 && bit_cnt_reg == tsw_pkg::CNT_LAST && !serial_sel_n) begin
      cmd_valid    <= 1'b1;
      cmd_data     <= {shift_reg[14:0], serial_din};
      last_cmd_reg <= {shift_reg[14:0], serial_din};
    end else begin
      cmd_valid    <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_LOW_SUPPLY: assert property (
    @(posedge clock) disable iff (!resetn)
    ##1 status_word_reg[tsw_pkg::BIT_LOW_SUPPLY] == $past(low_supply_in))
    else $error("low supply flag does not follow input");

  AST_RX_EMPTY: assert property (
    @(posedge clock) disable iff (!resetn)
    ##1 status_word_reg[tsw_pkg::BIT_RX_EMPTY] == $past(rx_fifo_empty_in))
    else $error("rx empty flag missing");

  AST_TX_STRENGTH: assert property (
    @(posedge clock) disable iff (!resetn)
    tx_mode |=> status_word_reg[tsw_pkg::BIT_SIG_STRENGTH] == $past(ant_strong))
    else $error("tx strength flag wrong");

  AST_RX_STRENGTH: assert property (
    @(posedge clock) disable iff (!resetn)
    !tx_mode |=> status_word_reg[tsw_pkg::BIT_SIG_STRENGTH] == $past(rssi_above))
    else $error("rx strength flag wrong");

  AST_QUALITY_LOCK: assert property (
    @(posedge clock) disable iff (!resetn)
    ##1 {status_word_reg[tsw_pkg::BIT_DATA_QUALITY], status_word_reg[tsw_pkg::BIT_CLK_LOCK]}
      == $past({data_quality_in, clock_lock_in}))
    else $error("quality or lock flag wrong");

  AST_AFC_TOGGLE: assert property (
    @(posedge clock) disable iff (!resetn)
    afc_cycle_done |=> ##1 status_word_reg[tsw_pkg::BIT_AFC_TOGGLE] != $past(afc_cycle_toggle, 2))
    else $error("afc toggle did not invert");

  AST_AFC_HOLD: assert property (
    @(posedge clock) disable iff (!resetn)
    !afc_cycle_done |=> $stable(afc_cycle_toggle))
    else $error("afc toggle moved without a cycle");

  AST_AFC_OFFSET: assert property (
    @(posedge clock) disable iff (!resetn)
    afc_cycle_done |-> ##2 status_word_reg[4:0] == $past({afc_offset_sign_in, afc_offset_value_in}, 2))
    else $error("afc offset not reported");

  AST_LEAD_BIT: assert property (
    @(posedge clock) disable iff (!resetn)
    (ser_state_reg == tsw_pkg::TSW_FIRST && sck_rise && serial_din && !serial_sel_n)
      |=> ser_state_reg == tsw_pkg::TSW_WRITE && shift_reg[15:0] == 16'h0001)
    else $error("leading 1 not decoded as command");

  AST_CLEAR_ON_READ: assert property (
    @(posedge clock) disable iff (!resetn)
    (read_clear && !wakeup_overflow) |=> !sticky_flags[1])
    else $error("wake-up flag not cleared by read");

  AST_RESET_ZERO: assert property (
    @(posedge clock) disable iff (!resetn)
    !por_seen_reg |-> status_word_reg == 16'h0000)
    else $error("status word not zero after reset");

  AST_POWER_ON: assert property (
    @(posedge clock) disable iff (!resetn)
    !por_seen_reg |=> ##1 status_word_reg[tsw_pkg::BIT_POWER_ON])
    else $error("power-on flag not raised");

  AST_SHIFT_OUT: assert property (
    @(posedge clock) disable iff (!resetn)
    (ser_state_reg == tsw_pkg::TSW_READ && sck_rise && !serial_sel_n)
      |=> serial_dout == $past(shift_reg[14]))
    else $error("status bit shifted out of order");

  AST_SNAPSHOT: assert property (
    @(posedge clock) disable iff (!resetn)
    ser_status_rd |=> serial_dout == $past(status_word_next[15]) && shift_reg == $past(status_word_next))
    else $error("status snapshot wrong");
endmodule : tsw_status_word

/* File: testbench/tsw_host_model.sv */
`timescale 1ns/1ps
module tsw_host_model (
  input  wire logic clock,
  output logic      serial_sel_n,
  output logic      serial_clk,
  output logic      serial_din,
  input  wire logic serial_dout
);
  initial begin
    serial_sel_n = 1'b1;
    serial_clk   = 1'b0;
    serial_din   = 1'b0;
  end
  // ****************************************
  // one frame, msb first
  // ****************************************
  // clock stands low outside frames; high 5 and low 3 core cycles keeps the edge detector honest
  task automatic frame(input logic [15:0] word, output logic [15:0] got);
    @(posedge clock);
    serial_sel_n <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 15; i >= 0; i--) begin
      serial_din <= word[i];
      repeat (3) @(posedge clock);
      serial_clk <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      got[i] = serial_dout;
      @(posedge clock);
      serial_clk <= 1'b0;
    end
    repeat (2) @(posedge clock);
    serial_sel_n <= 1'b1;
    // released line has no pull, so show the inverse rather than a stale value
    serial_din   <= ~serial_din;
    repeat (2) @(posedge clock);
  endtask : frame
endmodule : tsw_host_model

/* File: testbench/tsw_status_word_test.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tsw_status_word_test;
  logic        clock;
  logic        resetn;
  logic [3:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_rdata;
  logic        irq;
  logic        serial_sel_n;
  logic        serial_clk;
  logic        serial_din;
  logic        serial_dout;
  logic        cmd_valid;
  logic [15:0] cmd_data;
  logic        tx_mode;
  logic [5:0]  ev;
  logic [5:0]  lv;
  logic        afc_done;
  logic        afc_sgn_in;
  logic [3:0]  afc_val_in;
  logic        afc_tog;
  logic        afc_sgn;
  logic [3:0]  afc_val;
  logic [7:0]  cmd_seen;
  logic [15:0] rd;
  logic [15:0] got;
  int          n_errors;
  int          check_count;

  tsw_status_word dut (.clock(clock), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq), .serial_sel_n(serial_sel_n),
    .serial_clk(serial_clk), .serial_din(serial_din), .serial_dout(serial_dout), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .tx_mode(tx_mode), .tx_reg_ready(ev[0]), .rx_fill_reached(ev[1]),
    .tx_underrun(ev[2]), .rx_overflow(ev[3]), .wakeup_overflow(ev[4]), .ext_int_fall(ev[5]),
    .low_supply_in(lv[5]), .rx_fifo_empty_in(lv[4]), .ant_strong(lv[3]), .rssi_above(lv[2]),
    .data_quality_in(lv[1]), .clock_lock_in(lv[0]), .afc_cycle_done(afc_done),
    .afc_offset_sign_in(afc_sgn_in), .afc_offset_value_in(afc_val_in));

  tsw_host_model host (.clock(clock), .serial_sel_n(serial_sel_n), .serial_clk(serial_clk),
    .serial_din(serial_din), .serial_dout(serial_dout));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (cmd_valid === 1'b1) begin
      cmd_seen <= cmd_seen + 8'h01;
    end
  end

  // ****************************************
  // expectations and bus tasks
  // ****************************************
  function automatic logic [15:0] exp_word();
    logic [15:0] w;
    w = 16'h0000;
    w[10] = lv[5];
    w[9] = lv[4];
    w[8] = tx_mode ? lv[3] : lv[2];
    w[7] = lv[1];
    w[6] = lv[0];
    w[5] = afc_tog;
    w[4] = afc_sgn;
    w[3:0] = afc_val;
    return w;
  endfunction : exp_word

  function automatic logic [15:0] ev_bit(int i, logic m);
    case (i)
      0: return m ? 16'h8000 : 16'h0000;
      1: return m ? 16'h0000 : 16'h8000;
      2: return m ? 16'h2000 : 16'h0000;
      3: return m ? 16'h0000 : 16'h2000;
      4: return 16'h1000;
      default: return 16'h0800;
    endcase
  endfunction : ev_bit

  // host side scaling of the offset; the step value is arbitrary
  localparam int FREQ_STEP = 5;

  function automatic logic [15:0] afc_hz(input logic [3:0] o);
    return {{12{o[3]}}, o} * 16'(FREQ_STEP);
  endfunction : afc_hz

  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask : bus_write

  task automatic chk_read(input string nm, input logic [3:0] a, input logic [15:0] ex);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1;
    `CHK(nm, ex, bus_rdata)
  endtask : chk_read

  task automatic settle();
    repeat (3) @(posedge clock);
  endtask : settle

  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    $display("watchdog expired");
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] c0;
    logic [3:0] v;
    {resetn, bus_addr, bus_wdata, bus_wr, bus_rd, tx_mode, ev, lv} = '0;
    {afc_done, afc_sgn_in, afc_val_in, afc_tog, afc_sgn, afc_val, cmd_seen} = '0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'hac89ceda));
    repeat (6) @(posedge clock);
    `CHK("reset outputs", 19'h0, {bus_rdata, irq, serial_dout, cmd_valid})
    resetn <= 1'b1;
    settle();
    chk_read("power on", tsw_pkg::OFF_STATUS, 16'h4000);
    chk_read("power on cleared", tsw_pkg::OFF_STATUS, 16'h0000);
    chk_read("mask reset", tsw_pkg::OFF_IRQ_MASK, tsw_pkg::MASK_RST);
    bus_write(tsw_pkg::OFF_STATUS, 16'hffff);
    bus_write(tsw_pkg::OFF_LAST_CMD, 16'hffff);
    bus_write(4'hc, 16'hffff);
    chk_read("status ro", tsw_pkg::OFF_STATUS, 16'h0000);
    chk_read("last cmd ro", tsw_pkg::OFF_LAST_CMD, 16'h0000);
    chk_read("unmapped", 4'hc, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 24; k++) begin
      @(posedge clock);
      tx_mode <= 1'($urandom());
      lv <= 6'($urandom());
      settle();
      chk_read("levels", tsw_pkg::OFF_STATUS, exp_word());
    end
    $display("test levels done");
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 4'h8 : (k == 1) ? 4'h7 : 4'($urandom());
      @(posedge clock);
      afc_val_in <= v;
      afc_sgn_in <= v[3];
      afc_done <= 1'b1;
      @(posedge clock);
      afc_done <= 1'b0;
      afc_tog = ~afc_tog;
      afc_sgn = v[3];
      afc_val = v;
      settle();
      chk_read("afc", tsw_pkg::OFF_STATUS, exp_word());
    end
    $display("test afc done");
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 6; i++) begin
        @(posedge clock);
        tx_mode <= m[0];
        pulse(i);
        settle();
        chk_read("sticky set", tsw_pkg::OFF_STATUS, exp_word() | ev_bit(i, m[0]));
        chk_read("sticky clear", tsw_pkg::OFF_STATUS, exp_word());
      end
    end
    // event taken one edge before the read strobe must not be lost by the clear
    @(posedge clock);
    ev[4] <= 1'b1;
    @(posedge clock);
    ev[4] <= 1'b0;
    bus_addr <= tsw_pkg::OFF_STATUS;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1;
    `CHK("event then read", exp_word() | 16'h1000, bus_rdata)
    chk_read("event then read cleared", tsw_pkg::OFF_STATUS, exp_word());
    $display("test sticky done");
    bus_write(tsw_pkg::OFF_IRQ_MASK, 16'h1000);
    chk_read("mask rw", tsw_pkg::OFF_IRQ_MASK, 16'h1000);
    `CHK("irq idle", 1'b0, irq)
    pulse(4);
    settle();
    `CHK("irq raised", 1'b1, irq)
    bus_write(tsw_pkg::OFF_IRQ_MASK, 16'h0000);
    settle();
    `CHK("irq masked", 1'b0, irq)
    bus_write(tsw_pkg::OFF_IRQ_MASK, 16'h1000);
    settle();
    `CHK("irq unmasked", 1'b1, irq)
    chk_read("irq source", tsw_pkg::OFF_STATUS, exp_word() | 16'h1000);
    settle();
    `CHK("irq cleared", 1'b0, irq)
    $display("test irq done");
    pulse(5);
    settle();
    c0 = cmd_seen;
    // afc stays idle while the word is shifted out
    host.frame(16'h0000, got);
    `CHK("serial status", exp_word() | 16'h0800, got)
    `CHK("no command on read", c0, cmd_seen)
    `CHK("afc scaled", afc_hz(afc_val), afc_hz(got[3:0]))
    chk_read("serial cleared", tsw_pkg::OFF_STATUS, exp_word());
    rd = 16'h8000 | 16'($urandom());
    host.frame(rd, got);
    settle();
    `CHK("command count", c0 + 8'h01, cmd_seen)
    `CHK("command word", rd, cmd_data)
    chk_read("last command", tsw_pkg::OFF_LAST_CMD, rd);
    $display("test serial done");
    test_done();
  end
endmodule : tsw_status_word_test
